/* File: include/dew_pkg.sv */
// constants, field layouts and carriers for the data eeprom access block
// assumes one 10 MHz system clock and an ahb-lite register bus
//
// Function
// RULE1 - software loads address and data first
// RULE2 - permit then start in consecutive writes
// RULE3 - software masks interrupts around the start
// RULE4 - start ignored unless permit already set
// RULE5 - write timed by independent slow timer
// RULE6 - hardware clears write-start when done
// RULE7 - software polls start bit or waits interrupt
// RULE8 - write permit cleared at reset
// RULE9 - pointer high bytes reset to zero
// RULE10 - write completion raises interrupt request
// RULE11 - software enables memory and shared interrupt
// RULE12 - completion sets memory and shared flags
// RULE13 - vector only when enabled, stack free
// RULE14 - service clears shared flag only
// RULE15 - software avoids sleep during access
// RULE16 - software may read back written data
// RULE17 - every read reloads address and start
// RULE18 - control reached via pointer 01h:40h
// RULE19 - control bits 3..0, upper bits zero
// RULE20 - read end clears read-start, data valid
// RULE21 - software never sets both start bits
// RULE22 - registers frozen while write in progress
package dew_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFF_ADDR  = 8'h00;
   localparam logic [7:0] OFF_DATA  = 8'h04;
   localparam logic [7:0] OFF_P1LO  = 8'h08;
   localparam logic [7:0] OFF_P1HI  = 8'h0c;
   localparam logic [7:0] OFF_IND1  = 8'h10;
   localparam logic [7:0] OFF_P2LO  = 8'h14;
   localparam logic [7:0] OFF_P2HI  = 8'h18;
   localparam logic [7:0] OFF_IND2  = 8'h1c;
   localparam logic [7:0] OFF_IRQ   = 8'h20;

   // location of the control register behind the pointers
   localparam logic [7:0] CTRL_SECT = 8'h01;
   localparam logic [7:0] CTRL_LOC  = 8'h40;

   // interrupt register fields
   localparam int IRQ_GIE_BIT  = 0;
   localparam int IRQ_NVIE_BIT = 1;
   localparam int IRQ_MFIE_BIT = 2;
   localparam int IRQ_NVF_BIT  = 4;
   localparam int IRQ_MFF_BIT  = 5;

   // reset values
   localparam logic [7:0] PTR_RST  = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [5:0] ADDR_RST = 6'h00;

   // memory shape
   localparam int MEM_AW    = 6;
   localparam int MEM_DEPTH = 64;

   // timing: slow timer period and write length in its ticks
   localparam int CLK_PERIOD_NS  = 100;
   localparam int TICK_PERIOD_NS = 31250;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] WR_TICKS  = 8'h40;
   localparam logic [1:0] RD_CYCLES = 2'h2;

   typedef struct packed {
      logic [3:0] rsvd;
      logic       writePermit;
      logic       writeStart;
      logic       readPermit;
      logic       readStart;
   } dew_ctrl_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] off;
   } dew_aphase_s;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dew_state_e;

endpackage : dew_pkg

/* File: rtl/dew_tick.sv */
// free running divider standing in for the slow write timer
// its phase is unrelated to any bus access
`timescale 1ns/1ps
module dew_tick
   import dew_pkg::*;
#(
   parameter int DIV = TICK_CYCLES
) (
   input  wire logic clk_sys,  // system clock
   input  wire logic rst_n,    // sync reset, active low
   output logic      tick      // one-cycle pulse each period
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (cnt_r == LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= (cnt_r == LAST);
      end
   end

endmodule : dew_tick

/* File: rtl/dew_ctrl.sv */
// data eeprom access controller with ahb-lite register slave
// assumes a single slave on the bus, word accesses, zero wait states
`timescale 1ns/1ps
module dew_ctrl
   import dew_pkg::*;
(
   input  wire logic        clk_sys,    // system clock
   input  wire logic        rst_n,      // sync reset, active low
   input  wire logic        hsel,       // slave select
   input  wire logic [31:0] haddr,      // byte address
   input  wire logic [1:0]  htrans,     // transfer type
   input  wire logic        hwrite,     // write when high
   input  wire logic [2:0]  hsize,      // transfer size
   input  wire logic [31:0] hwdata,     // write data
   input  wire logic        hready,     // bus ready in
   output logic             hreadyout,  // slave ready
   output logic             hresp,      // always okay
   output logic [31:0]      hrdata,     // read data
   input  wire logic        stackFull,  // return stack is full
   input  wire logic        irqAck,     // cpu services vector
   output logic             irqReq      // branch to vector
);

   ////////////////////////////////////////////////////////////////////
   // storage and state

   logic [7:0]  mem [MEM_DEPTH];
   dew_aphase_s ap_r;
   dew_state_e  state_r;
   dew_ctrl_s   ctrl_r;
   logic [MEM_AW-1:0] nvAddrReg_r;
   logic [7:0]  nvDataReg_r;
   logic [7:0]  ptr1Low_r;
   logic [7:0]  ptr1High_r;
   logic [7:0]  ptr2Low_r;
   logic [7:0]  ptr2High_r;
   logic        globalIrqEnable_r;
   logic        nvIrqEnable_r;
   logic        mfIrqEnable_r;
   logic        nvIrqFlag_r;
   logic        mfIrqFlag_r;
   logic        permitFresh_r;
   logic [7:0]  ticksLeft_r;
   logic [1:0]  rdCnt_r;
   logic [31:0] hrdata_r;
   logic        tick;

   logic [7:0]  wdat;
   logic        busy;
   logic        ptr1Hit;
   logic        ptr2Hit;
   logic        wrAddr;
   logic        wrData;
   logic        wrCtrl;
   logic        wrIrq;
   logic        wrGo;
   logic        rdGo;
   logic        writeDone;
   logic        readDone;
   logic [7:0]  irqVal;
   logic [7:0]  rdVal;

   ////////////////////////////////////////////////////////////////////
   // slow timer

   dew_tick #(
      .DIV (TICK_CYCLES)
   ) u_tick (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // bus slave

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ap_r <= '0;
      end else if (hready) begin
         ap_r.wr  <= hsel && htrans[1] && hwrite;
         ap_r.rd  <= hsel && htrans[1] && !hwrite;
         ap_r.off <= haddr[7:0];
      end
   end

   assign wdat    = hwdata[7:0];
   assign busy    = (state_r != ST_IDLE);
   assign ptr1Hit = (ptr1High_r == CTRL_SECT) && (ptr1Low_r == CTRL_LOC);
   assign ptr2Hit = (ptr2High_r == CTRL_SECT) && (ptr2Low_r == CTRL_LOC);
   // address, data and control writes during an operation are dropped silently
   assign wrAddr  = ap_r.wr && (ap_r.off == OFF_ADDR) && !busy; // RULE22
   assign wrData  = ap_r.wr && (ap_r.off == OFF_DATA) && !busy; // RULE22
   assign wrCtrl  = ap_r.wr && !busy                            // RULE22
                 && (((ap_r.off == OFF_IND1) && ptr1Hit)        // RULE18
                 ||  ((ap_r.off == OFF_IND2) && ptr2Hit));
   assign wrIrq   = ap_r.wr && (ap_r.off == OFF_IRQ);

   always_comb begin
      irqVal = 8'h00;
      irqVal[IRQ_GIE_BIT]  = globalIrqEnable_r;
      irqVal[IRQ_NVIE_BIT] = nvIrqEnable_r;
      irqVal[IRQ_MFIE_BIT] = mfIrqEnable_r;
      irqVal[IRQ_NVF_BIT]  = nvIrqFlag_r;
      irqVal[IRQ_MFF_BIT]  = mfIrqFlag_r;
   end

   // read value chosen at the address phase; unmapped reads give zero
   always_comb begin
      rdVal = 8'h00;
      unique case (haddr[7:0])
         OFF_ADDR: rdVal = {2'h0, nvAddrReg_r};
         OFF_DATA: rdVal = nvDataReg_r;
         OFF_P1LO: rdVal = ptr1Low_r;
         OFF_P1HI: rdVal = ptr1High_r;
         OFF_IND1: rdVal = ptr1Hit ? 8'(ctrl_r) : 8'h00;  // RULE18
         OFF_P2LO: rdVal = ptr2Low_r;
         OFF_P2HI: rdVal = ptr2High_r;
         OFF_IND2: rdVal = ptr2Hit ? 8'(ctrl_r) : 8'h00;
         OFF_IRQ:  rdVal = irqVal;
         default:  rdVal = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hrdata_r <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata_r <= {24'h00_0000, rdVal};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pointers

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ptr1Low_r  <= PTR_RST;
         ptr1High_r <= PTR_RST;   // RULE9
         ptr2Low_r  <= PTR_RST;
         ptr2High_r <= PTR_RST;   // RULE9
      end else if (ap_r.wr) begin
         if (ap_r.off == OFF_P1LO) ptr1Low_r  <= wdat;
         if (ap_r.off == OFF_P1HI) ptr1High_r <= wdat;
         if (ap_r.off == OFF_P2LO) ptr2Low_r  <= wdat;
         if (ap_r.off == OFF_P2HI) ptr2High_r <= wdat;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // address and data registers

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         nvAddrReg_r <= ADDR_RST;
      end else if (wrAddr) begin
         nvAddrReg_r <= wdat[MEM_AW-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         nvDataReg_r <= DATA_RST;
      end else if (readDone) begin
         nvDataReg_r <= mem[nvAddrReg_r];   // RULE20
      end else if (wrData) begin
         nvDataReg_r <= wdat;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control register and start qualification

   // write start only counts right after the write that raised the permit;
   // one start bit at a time, both together start nothing
   assign wrGo = wrCtrl && wdat[2] && !wdat[0]
              && ctrl_r.writePermit && permitFresh_r;   // RULE2 RULE4
   assign rdGo = wrCtrl && wdat[0] && !wdat[2] && ctrl_r.readPermit;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         permitFresh_r <= 1'b0;
      end else if (ap_r.wr) begin
         permitFresh_r <= wrCtrl && wdat[3] && !ctrl_r.writePermit; // RULE2
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r <= '0;   // RULE8
      end else begin
         if (wrCtrl) begin
            ctrl_r.writePermit <= wdat[3];
            ctrl_r.readPermit  <= wdat[1];
         end
         if (writeDone) begin
            ctrl_r.writeStart <= 1'b0;   // RULE6
         end else if (wrGo) begin
            ctrl_r.writeStart <= 1'b1;
         end
         if (readDone) begin
            ctrl_r.readStart <= 1'b0;   // RULE20
         end else if (rdGo) begin
            ctrl_r.readStart <= 1'b1;
         end
         ctrl_r.rsvd <= 4'h0;   // RULE19
      end
   end

   ////////////////////////////////////////////////////////////////////
   // access sequencer

   // write length counts slow ticks whose phase is free running,
   // so the cycle count varies by up to one tick period
   assign writeDone = (state_r == ST_WRITE) && tick
                   && (ticksLeft_r == 8'h01);   // RULE5
   assign readDone  = (state_r == ST_READ) && (rdCnt_r == 2'h1);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (wrGo) begin
                  state_r <= ST_WRITE;
               end else if (rdGo) begin
                  state_r <= ST_READ;
               end
            end
            ST_READ: begin
               if (readDone) state_r <= ST_IDLE;
            end
            ST_WRITE: begin
               if (writeDone) state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ticksLeft_r <= 8'h00;
      end else if (wrGo) begin
         ticksLeft_r <= WR_TICKS;
      end else if ((state_r == ST_WRITE) && tick) begin
         ticksLeft_r <= ticksLeft_r - 8'h01;   // RULE5
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdCnt_r <= 2'h0;
      end else if (rdGo) begin
         rdCnt_r <= RD_CYCLES;
      end else if (state_r == ST_READ) begin
         rdCnt_r <= rdCnt_r - 2'h1;
      end
   end

   // array has no reset; contents persist as in the real cell
   always_ff @(posedge clk_sys) begin
      if (writeDone) begin
         mem[nvAddrReg_r] <= nvDataReg_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt enables and flags

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         globalIrqEnable_r <= 1'b0;
         nvIrqEnable_r     <= 1'b0;
         mfIrqEnable_r     <= 1'b0;
      end else if (wrIrq) begin
         globalIrqEnable_r <= wdat[IRQ_GIE_BIT];
         nvIrqEnable_r     <= wdat[IRQ_NVIE_BIT];
         mfIrqEnable_r     <= wdat[IRQ_MFIE_BIT];
      end
   end

   // flags: writing 0 clears, writing 1 keeps; a new set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         nvIrqFlag_r <= 1'b0;
      end else if (writeDone) begin
         nvIrqFlag_r <= 1'b1;   // RULE10 RULE12
      end else if (wrIrq && !wdat[IRQ_NVF_BIT]) begin
         nvIrqFlag_r <= 1'b0;   // RULE14
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mfIrqFlag_r <= 1'b0;
      end else if (writeDone) begin
         mfIrqFlag_r <= 1'b1;   // RULE12
      end else if (irqAck || (wrIrq && !wdat[IRQ_MFF_BIT])) begin
         mfIrqFlag_r <= 1'b0;   // RULE14
      end
   end

   assign irqReq = globalIrqEnable_r && nvIrqEnable_r && mfIrqEnable_r
                && mfIrqFlag_r && nvIrqFlag_r && !stackFull;   // RULE13

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_start_needs_permit: assert property ( // RULE4
      $rose(ctrl_r.writeStart) |-> $past(ctrl_r.writePermit)
         && $past(permitFresh_r))
      else $error("write started without permit");

   a_start_consecutive: assert property ( // RULE2
      wrCtrl && wdat[2] && !wdat[0] && ctrl_r.writePermit && permitFresh_r
         && !busy |=> state_r == ST_WRITE && ctrl_r.writeStart)
      else $error("timely start did not begin write");

   a_write_lasts: assert property ( // RULE5
      $rose(ctrl_r.writeStart) |-> ctrl_r.writeStart [*8])
      else $error("write ended too soon");

   a_done_clears_wr: assert property ( // RULE6
      writeDone |=> !ctrl_r.writeStart && state_r == ST_IDLE)
      else $error("write start not cleared at end");

   a_reset_permit: assert property ( // RULE8
      $rose(rst_n) |-> !ctrl_r.writePermit && !ctrl_r.writeStart)
      else $error("permit not clear after reset");

   a_reset_pointers: assert property ( // RULE9
      $rose(rst_n) |-> ptr1High_r == 8'h00 && ptr2High_r == 8'h00)
      else $error("pointer high bytes not zero after reset");

   a_done_flags: assert property ( // RULE12
      writeDone |=> nvIrqFlag_r && mfIrqFlag_r)
      else $error("completion flags not set");

   a_irq_gate: assert property ( // RULE13
      irqReq |-> !stackFull && globalIrqEnable_r && mfIrqFlag_r)
      else $error("vector request while gated");

   a_ack_keeps_nv: assert property ( // RULE14
      irqAck && nvIrqFlag_r && !writeDone && !wrIrq
         |=> nvIrqFlag_r && !mfIrqFlag_r)
      else $error("service changed wrong flag");

   a_read_ends: assert property ( // RULE20
      $rose(ctrl_r.readStart) |-> ##[1:4] !ctrl_r.readStart)
      else $error("read start not cleared");

   a_busy_hold: assert property ( // RULE22
      state_r == ST_WRITE |=> $stable(nvAddrReg_r) && $stable(nvDataReg_r))
      else $error("registers changed during write");

   a_upper_zero: assert property ( // RULE19
      ctrl_r.rsvd == 4'h0)
      else $error("reserved control bits set");

   c_write_done: cover property (writeDone);
   c_read_done:  cover property (readDone);
   c_refused:    cover property (wrCtrl && wdat[2] && !permitFresh_r);
   c_vector:     cover property (irqReq);

endmodule : dew_ctrl

/* File: test/tb.sv */
// self-checking bench for the data eeprom access controller
// assumes dew_ctrl alone on an ahb-lite bus, hready tied to hreadyout
`timescale 1ns/1ps
module tb;
   import dew_pkg::*;

   typedef struct {
      string       nm;
      logic [31:0] ex;
      bit          ck;
   } dew_note_s;

   localparam int LIMIT = 70000;

   logic        clk_sys;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        stackFull;
   logic        irqAck;
   logic        irqReq;
   logic        rdPend;
   dew_note_s   notes[$];
   dew_note_s   curNote;
   int          miscompares;
   int          num_checks;
   int          cyc;
   logic [5:0]  addrA;
   logic [7:0]  datA;
   logic [7:0]  datB;

   dew_ctrl dut_u (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .hsel     (hsel),
      .haddr    (haddr),
      .htrans   (htrans),
      .hwrite   (hwrite),
      .hsize    (3'b010),
      .hwdata   (hwdata),
      .hready   (hreadyout),
      .hreadyout(hreadyout),
      .hresp    (hresp),
      .hrdata   (hrdata),
      .stackFull(stackFull),
      .irqAck   (irqAck),
      .irqReq   (irqReq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] ex,
                        input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         miscompares++;
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   // read data stands in the data phase, so it is taken at its closing edge
   always @(posedge clk_sys) begin
      if (rdPend) begin
         check("hresp", 32'h0, {31'h0, hresp});
         check("hreadyout", 32'h1, {31'h0, hreadyout});
         if (notes.size() == 0) begin
            check("note queue", 32'h1, 32'h0);
         end else begin
            curNote = notes.pop_front();
            if (curNote.ck)
               check(curNote.nm, curNote.ex, hrdata);
         end
      end
      rdPend <= rst_n && hsel && htrans[1] && !hwrite && hreadyout;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == LIMIT) begin
         miscompares++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [7:0] off,
                       input logic [31:0] wd);
      haddr  <= {24'h00_0000, off};
      hwrite <= w;
      htrans <= 2'b10;
      hsel   <= 1'b1;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
   endtask : xfer

   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      xfer(1'b1, off, {24'h00_0000, d});
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] off,
                     input logic [7:0] ex, input bit ck = 1'b1);
      dew_note_s n;
      n.nm = nm;
      n.ex = {24'h00_0000, ex};
      n.ck = ck;
      notes.push_back(n);
      xfer(1'b0, off, 32'h0000_0000);
   endtask : rd

   // polls a control bit until it self-clears, bounded
   task automatic waitClr(input logic [7:0] port, input logic [7:0] m);
      int k;
      k = 0;
      do begin
         rd("poll", port, 8'h00, 1'b0);
         k++;
      // hrdata only moves at a read address phase, so it still holds here
      end while ((hrdata[7:0] & m) != 8'h00 && k < 15000);
      check("poll done", 32'h0, {24'h0, hrdata[7:0] & m});
   endtask : waitClr

   task automatic writeByte(input logic [7:0] port, input logic [5:0] a,
                            input logic [7:0] d, input logic [7:0] ie);
      int t0;
      logic ok;
      wr(port, 8'h00);
      wr(OFF_ADDR, {2'b00, a});
      wr(OFF_DATA, d);
      wr(OFF_IRQ, ie & 8'hfe);
      wr(port, 8'h08);
      wr(port, 8'h0c);
      t0 = cyc;
      wr(OFF_IRQ, ie);
      rd("busy ctrl", port, 8'h0c);
      check("irq while busy", 32'h0, {31'h0, irqReq});
      wr(OFF_DATA, ~d);
      wr(OFF_ADDR, ~{2'b00, a});
      wr(port, 8'h00);
      rd("frozen ctrl", port, 8'h0c);
      waitClr(port, 8'h04);
      ok = (cyc - t0 >= (int'(WR_TICKS) - 1) * TICK_CYCLES) &&
           (cyc - t0 <= int'(WR_TICKS) * TICK_CYCLES + 20);
      check("write length", 32'h1, {31'h0, ok});
      rd("ctrl after", port, 8'h08);
      rd("addr kept", OFF_ADDR, {2'b00, a});
      rd("data kept", OFF_DATA, d);
   endtask : writeByte

   task automatic readByte(input logic [7:0] port, input logic [5:0] a,
                           input logic [7:0] d);
      wr(OFF_ADDR, {2'b00, a});
      wr(port, 8'h02);
      wr(port, 8'h03);
      waitClr(port, 8'h01);
      rd("read data", OFF_DATA, d);
      rd("ctrl idle", port, 8'h02);
   endtask : readByte

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      stackFull = 1'b0;
      irqAck = 1'b0;
      rdPend = 1'b0;
      miscompares = 0;
      num_checks = 0;
      cyc = 0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      void'($urandom(32'h07a6));
      addrA = 6'($urandom % 63);
      datA = 8'($urandom);
      datB = 8'($urandom);
      // reset state and the sector guard
      rd("addr rst", OFF_ADDR, 8'h00);
      rd("data rst", OFF_DATA, 8'h00);
      rd("p1 high rst", OFF_P1HI, 8'h00);
      rd("p2 high rst", OFF_P2HI, 8'h00);
      rd("irq rst", OFF_IRQ, 8'h00);
      wr(OFF_IND1, 8'h08);
      rd("ctrl hidden", OFF_IND1, 8'h00);
      wr(8'h24, 8'hff);
      rd("unmapped", 8'h24, 8'h00);
      wr(OFF_P1LO, CTRL_LOC);
      wr(OFF_P1HI, CTRL_SECT);
      rd("permit rst", OFF_IND1, 8'h00);
      $display("test reset done");
      // control field layout and start refusals
      wr(OFF_IND1, 8'hf2);
      rd("ctrl upper", OFF_IND1, 8'h02);
      wr(OFF_IND1, 8'h04);
      rd("start no permit", OFF_IND1, 8'h00);
      wr(OFF_IND1, 8'h08);
      wr(OFF_ADDR, 8'h01);
      wr(OFF_IND1, 8'h0c);
      rd("start late", OFF_IND1, 8'h08);
      wr(OFF_IND1, 8'h0c);
      rd("start stale", OFF_IND1, 8'h08);
      $display("test refusals done");
      // write with interrupts enabled
      wr(OFF_IRQ, 8'h07);
      writeByte(OFF_IND1, addrA, datA, 8'h07);
      rd("flags set", OFF_IRQ, 8'h37);
      check("irq raised", 32'h1, {31'h0, irqReq});
      stackFull <= 1'b1;
      @(posedge clk_sys);
      check("stack full", 32'h0, {31'h0, irqReq});
      stackFull <= 1'b0;
      irqAck <= 1'b1;
      @(posedge clk_sys);
      irqAck <= 1'b0;
      rd("after ack", OFF_IRQ, 8'h17);
      check("irq after ack", 32'h0, {31'h0, irqReq});
      wr(OFF_IRQ, 8'h07);
      rd("flag cleared", OFF_IRQ, 8'h07);
      $display("test write one done");
      // second write via the other pointer, interrupts masked
      wr(OFF_IRQ, 8'h00);
      wr(OFF_P2LO, CTRL_LOC);
      wr(OFF_P2HI, CTRL_SECT);
      writeByte(OFF_IND2, addrA + 6'h01, datB, 8'h00);
      rd("masked flags", OFF_IRQ, 8'h30);
      check("irq masked", 32'h0, {31'h0, irqReq});
      $display("test write two done");
      // read both bytes back, reloading the address each time
      readByte(OFF_IND1, addrA, datA);
      readByte(OFF_IND2, addrA + 6'h01, datB);
      $display("test read back done");
      conclude();
   end

endmodule : tb
